// file: dv/rsp_stall.sv
`timescale 1ns/100ps
`default_nettype none
module rsp_stall (
    input wire logic i_clk,
    output logic o_ready
);
    // requester side accepting answers with random stalls
    always @(negedge i_clk)
        o_ready <= ($urandom % 4) != 0;
endmodule // rsp_stall
`default_nettype wire

// file: dv/surface_access_monitor.sv
`timescale 1ns/100ps
`default_nettype none
module surface_access_monitor (
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_req_valid,
    input wire logic o_req_ready,
    input wire logic [1:0] i_req_kind,
    input wire logic i_req_typed,
    input wire logic [13:0] i_req_desc,
    input wire logic i_req_has_header,
    input wire logic [15:0] i_req_pixel_mask,
    input wire logic [15:0] i_req_exec_mask,
    input wire logic o_rsp_valid,
    input wire logic i_rsp_ready,
    input wire logic [127:0] o_rsp_data,
    input wire logic [15:0] o_slot_mask,
    input wire logic o_bad_encoding
);
    // ----------------------------------------
    // request take and untyped read decode
    // ----------------------------------------
    wire take = i_req_valid && o_req_ready;
    wire rd = take && i_req_kind == 2'h0 && !i_req_typed;
    wire [1:0] md = i_req_desc[13:12];
    wire hd = i_req_has_header;
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_reset);
    property p_busy; take |=> !o_req_ready [*4]; endproperty
    a_busy: assert property (p_busy) else $error("ready too early");
    property p_hold; o_rsp_valid && !i_rsp_ready |=> o_rsp_valid && $stable(o_rsp_data); endproperty
    a_hold: assert property (p_hold) else $error("response dropped");
    property p_m16; rd && md == 2'h1 && hd |=> o_slot_mask == $past(i_req_exec_mask & i_req_pixel_mask); endproperty
    a_m16: assert property (p_m16) else $error("slot mask 16");
    property p_m8; rd && md == 2'h2 && hd |=> o_slot_mask[7:0] == $past(i_req_exec_mask[7:0] & i_req_pixel_mask[7:0]);
    endproperty
    a_m8: assert property (p_m8) else $error("slot mask 8");
    property p_n8; rd && md == 2'h2 && !hd |=> o_slot_mask == {8'h0, $past(i_req_exec_mask[7:0])}; endproperty
    a_n8: assert property (p_n8) else $error("slot mask no header");
    property p_n16; rd && md == 2'h1 && !hd |=> o_slot_mask == $past(i_req_exec_mask); endproperty
    a_n16: assert property (p_n16) else $error("slot mask pixel default");
    property p_m42; rd && md == 2'h0 |=> o_slot_mask == {14'h0, |$past(i_req_exec_mask[7:4]), |$past(i_req_exec_mask[3:0])};
    endproperty
    a_m42: assert property (p_m42) else $error("slot mask 4x2");
    property p_rsvd; rd && md == 2'h3 |-> ##[1:2] o_bad_encoding; endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved mode taken");
    property p_op0; take && i_req_typed && i_req_kind == 2'h2 && i_req_desc[11:8] == 4'h0 |-> ##[1:2] o_bad_encoding;
    endproperty
    a_op0: assert property (p_op0) else $error("typed op zero taken");
    property p_ans; rd && md != 2'h3 |-> ##[1:6] o_rsp_valid; endproperty
    a_ans: assert property (p_ans) else $error("no read answer");
endmodule // surface_access_monitor
`default_nettype wire

// file: dv/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "surface_access_defines.vh"
module tb;
    logic i_clk, i_reset, i_req_valid, o_req_ready, i_req_typed, i_req_has_header, i_surf_array;
    logic o_rsp_valid, i_rsp_ready, o_rsp_active, o_bad_encoding;
    logic [1:0] i_req_kind, i_surf_format;
    logic [2:0] i_surf_type;
    logic [3:0] i_req_slot, o_rsp_chan_en, op;
    logic [13:0] i_req_desc;
    logic [15:0] i_req_pixel_mask, i_req_exec_mask, o_slot_mask;
    logic [7:0] i_surf_dwords, i_surf_pitch, i_surf_slice;
    logic [31:0] i_addr_u, i_addr_v, i_addr_r, cur, nw, a, b;
    logic [63:0] i_src0, i_src1, x;
    logic [127:0] i_wdata, o_rsp_data;
    logic [65:0] e;
    logic [65:0] q[$];
    int mismatches = 0, samples_checked = 0, i, n;
    surface_access_unit DUT (
        .i_clk(i_clk), .i_reset(i_reset), .i_req_valid(i_req_valid), .o_req_ready(o_req_ready),
        .i_req_kind(i_req_kind), .i_req_typed(i_req_typed), .i_req_desc(i_req_desc),
        .i_req_has_header(i_req_has_header), .i_req_pixel_mask(i_req_pixel_mask),
        .i_req_exec_mask(i_req_exec_mask), .i_req_slot(i_req_slot), .i_surf_type(i_surf_type),
        .i_surf_array(i_surf_array), .i_surf_format(i_surf_format), .i_surf_dwords(i_surf_dwords),
        .i_surf_pitch(i_surf_pitch), .i_surf_slice(i_surf_slice), .i_addr_u(i_addr_u), .i_addr_v(i_addr_v),
        .i_addr_r(i_addr_r), .i_wdata(i_wdata), .i_src0(i_src0), .i_src1(i_src1), .o_rsp_valid(o_rsp_valid),
        .i_rsp_ready(i_rsp_ready), .o_rsp_data(o_rsp_data), .o_rsp_chan_en(o_rsp_chan_en),
        .o_rsp_active(o_rsp_active), .o_slot_mask(o_slot_mask), .o_bad_encoding(o_bad_encoding));
    rsp_stall u_sink (.i_clk(i_clk), .o_ready(i_rsp_ready));
    always #2 i_clk = ~i_clk;
    // ----------------------------------------
    // reference model and helpers
    // ----------------------------------------
    function automatic [31:0] nv(input [3:0] c, input [31:0] o, s, t);
        case (c)
            4'h1: nv = o & s;
            4'h2: nv = o | s;
            4'h3: nv = o ^ s;
            4'h4: nv = s;
            4'h5: nv = o + 1;
            4'h6: nv = o - 1;
            4'h7: nv = o + s;
            4'h8: nv = o - s;
            4'h9: nv = s - o;
            4'ha: nv = ($signed(o) > $signed(s)) ? o : s;
            4'hb: nv = ($signed(o) < $signed(s)) ? o : s;
            4'hc: nv = (o > s) ? o : s;
            4'hd: nv = (o < s) ? o : s;
            4'he: nv = (s == o) ? t : o;
            default: nv = o - 1;
        endcase
    endfunction
    task cmp(input string nm, input [63:0] ex, input [63:0] got);
        samples_checked++;
        if (ex !== got)
        begin
            mismatches++;
            $display("CHECK FAILED %s exp %h got %h", nm, ex, got);
        end
    endtask
    task test_done;
        $display("checks %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task req(input [1:0] k, input t, input [13:0] d, input [7:0] w, input [63:0] s0, input [63:0] s1,
             input [65:0] ex, input p);
        @(negedge i_clk);
        {i_req_kind, i_req_typed, i_req_desc, i_addr_u, i_src0, i_src1} = {k, t, d, 22'h0, w, 2'h0, s0, s1};
        i_req_has_header = 1'($urandom);
        i_req_pixel_mask = 16'($urandom) | 16'h1;
        i_req_exec_mask = 16'($urandom) | 16'h1;
        i_surf_type = t ? `SURF_1D : `SURF_BUF;
        i_addr_v = $urandom; // ignored by raw buffers and non-array 1D
        i_wdata = {s1, s0};
        i_req_valid = 1'b1;
        for (n = 0; n < 99 && !o_req_ready; n++) @(negedge i_clk);
        @(posedge i_clk);
        if (p) q.push_back(ex);
        @(negedge i_clk) i_req_valid = 1'b0;
        repeat (5) @(negedge i_clk);
    endtask
    task atom(input [3:0] c, input [7:0] w, input [63:0] s0, input [63:0] s1, input [65:0] ex);
        req(`KIND_ATOMIC, 1'b0, {2'b10, c, 8'h0}, w, s0, s1, ex, 1'b1);
    endtask
    task rd(input [7:0] w, input [31:0] ex);
        req(`KIND_READ, 1'b0, {2'($urandom % 3), 4'he, 8'h0}, w, 0, 0, {2'b10, 32'h0, ex}, 1'b1);
    endtask
    always @(posedge i_clk)
        if (o_rsp_valid && i_rsp_ready && o_rsp_chan_en[0])
        begin
            if (q.size() == 0)
                cmp("extra_rsp", 64'h0, 64'h1);
            else
            begin
                e = q.pop_front();
                if (e[65])
                    cmp("rsp", e[63:0], e[64] ? o_rsp_data[63:0] : {32'h0, o_rsp_data[31:0]});
            end
        end
    initial
    begin
        #40000;
        mismatches++;
        test_done;
    end
    initial
    begin
        {i_clk, i_reset, i_req_valid, i_req_typed, i_req_has_header, i_surf_array} = 6'h10;
        {i_req_kind, i_req_desc, i_req_slot, i_surf_format, i_surf_type} = {2'h0, 14'h0, 4'h0, `FMT_UINT, `SURF_BUF};
        {i_req_pixel_mask, i_req_exec_mask, i_addr_u, i_addr_v, i_addr_r} = '0;
        {i_surf_dwords, i_surf_pitch, i_surf_slice, i_wdata, i_src0, i_src1} = {8'h40, 8'h4, 8'h10, 256'h0};
        n = $urandom(32'h739c828f);
        repeat (16) @(posedge i_clk);
        @(negedge i_clk) i_reset = 1'b0;
        cur = 32'hffffffff;
        atom(4'h4, 8'h04, {32'h0, cur}, 0, 0);
        for (i = 0; i < 30; i++)
        begin
            op = 4'(i % 15 + 1);
            a = (i == 13) ? cur : $urandom;
            b = $urandom;
            nw = nv(op, cur, a, b);
            atom(op, 8'h04, {32'h0, a}, {32'h0, b}, {2'b10, 32'h0, (op == 4'hf) ? nw : cur});
            cur = nw;
        end
        for (i = 0; i < 8; i++) rd(8'h04, cur);
        a = $urandom;
        b = $urandom;
        x = {$urandom, $urandom};
        atom(4'h4, 8'h08, {32'h0, a}, 0, 0);
        atom(4'h4, 8'h09, {32'h0, b}, 0, 0);
        atom(4'h0, 8'h08, {b, a}, x, {2'b11, b, a}); // qword aligned
        rd(8'h08, x[31:0]);
        rd(8'h09, x[63:32]);
        atom(4'h4, 8'h30, {32'h0, a}, 0, 0);
        i_surf_dwords = 8'h20;
        atom(4'h7, 8'h30, {32'h0, b}, 0, 66'h2_0000_0000_0000_0000);
        rd(8'h30, 32'h0);
        i_surf_dwords = 8'h40;
        rd(8'h30, a);
        x = {$urandom, $urandom};
        req(`KIND_WRITE, 1'b0, {2'h2, 4'hc, 8'h0}, 8'h10, x, 0, {2'b10, 64'h0}, 1'b1);
        req(`KIND_READ, 1'b0, {2'h1, 4'hc, 8'h0}, 8'h10, 0, 0, {2'b11, x}, 1'b1);
        repeat (20) @(negedge i_clk);
        req(`KIND_READ, 1'b0, {2'h3, 4'he, 8'h0}, 8'h04, 0, 0, {2'b10, 64'h0}, 1'b1);
        cmp("bad_mode", 64'h1, {63'h0, o_bad_encoding});
        req(`KIND_ATOMIC, 1'b1, {2'b00, 4'h0, 8'h0}, 8'h04, 0, 0, {2'b10, 64'h0}, 1'b1);
        cmp("bad_op", 64'h1, {63'h0, o_bad_encoding});
        repeat (20) @(negedge i_clk);
        rd(8'h04, cur);
        repeat (20) @(negedge i_clk);
        cmp("queue_left", 64'h0, 64'(q.size()));
        test_done;
    end
endmodule // tb
bind surface_access_unit surface_access_monitor u_mon (
    .i_clk(i_clk), .i_reset(i_reset), .i_req_valid(i_req_valid), .o_req_ready(o_req_ready),
    .i_req_kind(i_req_kind), .i_req_typed(i_req_typed), .i_req_desc(i_req_desc),
    .i_req_has_header(i_req_has_header), .i_req_pixel_mask(i_req_pixel_mask),
    .i_req_exec_mask(i_req_exec_mask), .o_rsp_valid(o_rsp_valid), .i_rsp_ready(i_rsp_ready),
    .o_rsp_data(o_rsp_data), .o_slot_mask(o_slot_mask), .o_bad_encoding(o_bad_encoding));
`default_nettype wire

// file: rtl/result_fifo.v
`timescale 1ns/100ps
`default_nettype none
module result_fifo #(
    parameter WIDTH = 34,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire i_clk,
    input wire i_reset,
    input wire i_valid,
    output wire o_ready,
    input wire [WIDTH-1:0] i_data,
    output wire o_valid,
    input wire i_ready,
    output wire [WIDTH-1:0] o_data
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW:0] wp_r;
    reg [AW:0] rp_r;
    wire full = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
    wire empty = (wp_r == rp_r);
    assign o_ready = ~full;
    assign o_valid = ~empty;
    assign o_data = mem_r[rp_r[AW-1:0]];
    always @(posedge i_clk)
    begin
        if (i_reset)
        begin
            wp_r <= {(AW+1){1'b0}};
            rp_r <= {(AW+1){1'b0}};
        end
        else
        begin
            if (i_valid && !full)
            begin
                mem_r[wp_r[AW-1:0]] <= i_data;
                wp_r <= wp_r + 1'b1;
            end
            if (i_ready && !empty)
                rp_r <= rp_r + 1'b1;
        end
    end
endmodule // result_fifo
`default_nettype wire

// file: rtl/surface_access_defines.vh
`ifndef SURFACE_ACCESS_DEFINES_VH
`define SURFACE_ACCESS_DEFINES_VH
// message kinds
`define KIND_READ 2'h0
`define KIND_WRITE 2'h1
`define KIND_ATOMIC 2'h2
// slot modes (untyped descriptor bits 13:12)
`define SLOT_4X2 2'h0
`define SLOT_16 2'h1
`define SLOT_8 2'h2
`define SLOT_RSVD 2'h3
// descriptor field positions
`define DESC_SLOT_GROUP_BIT 13
`define DESC_MODE_HI 13
`define DESC_MODE_LO 12
`define DESC_CHMASK_HI 11
`define DESC_CHMASK_LO 8
// atomic operation codes
`define ATOMIC_COMPARE_WRITE_64 4'h0
`define ATOMIC_AND 4'h1
`define ATOMIC_OR 4'h2
`define ATOMIC_XOR 4'h3
`define ATOMIC_MOVE 4'h4
`define ATOMIC_INCREMENT 4'h5
`define ATOMIC_DECREMENT 4'h6
`define ATOMIC_ADD 4'h7
`define ATOMIC_SUBTRACT 4'h8
`define ATOMIC_REVERSE_SUBTRACT 4'h9
`define ATOMIC_SIGNED_MAX 4'ha
`define ATOMIC_SIGNED_MIN 4'hb
`define ATOMIC_UNSIGNED_MAX 4'hc
`define ATOMIC_UNSIGNED_MIN 4'hd
`define ATOMIC_COMPARE_WRITE 4'he
`define ATOMIC_PRE_DECREMENT 4'hf
// surface types
`define SURF_1D 3'h0
`define SURF_2D 3'h1
`define SURF_3D 3'h2
`define SURF_BUF 3'h3
`define SURF_STRBUF 3'h4
// typed formats
`define FMT_UINT 2'h0
`define FMT_SINT 2'h1
`define FMT_FLOAT 2'h2
// memory geometry
`define MEM_AW 8
`define MEM_WORDS 256
`define FIFO_DEPTH 4
`endif

// file: rtl/surface_access_unit.v
// Notes on behaviour
// R01: atomic read and write happen in one cycle, nothing intervenes.
// R02: and/or/xor/mov/inc/dec/add/sub/rsub/max/min; return old, predec returns new.
// R03: compare-write stores src1 when src0 equals old; returns old.
// R04: 64-bit compare-write on two dwords, returns full 8-byte old.
// R05: requester keeps 64-bit compare-write off shared memory, 8-byte aligned.
// R06: signed max/min compare signed, unsigned compare unsigned, rest unsigned.
// R07: add, sub, inc, dec wrap silently.
// R08: raw buffer uses U as byte offset, dword aligned.
// R09: structured buffer: U element index, V byte offset.
// R10: up to four dwords, red lowest address.
// R11: atomics touch only the first dword; the 64-bit compare-write here touches two.
// R12: typed data converted per uint, sint, or float format.
// R13: untyped data moves unchanged.
// R14: requester uses 32-bit int formats for typed atomics, typed only eight-slot.
// R15: sixteen-slot mode ANDs exec mask with 16-bit header mask.
// R16: eight-slot ANDs low exec bits with chosen header half.
// R17: without header, exec mask alone, low 8 in eight-slot.
// R18: 4x2 ORs each nibble of low exec byte into two slot enables.
// R19: out-of-bounds writes dropped, reads return zero.
// R20: descriptor bit 13 picks slot group for typed, ignored headerless.
// R21: bits 11:8 mask alpha..red; all four set never issued.
// R22: untyped bits 13:12 slot mode: 4x2, sixteen, eight, reserved.
// R23: U,V,R,LOD interpreted per surface type; unused ones ignored.
// R24: atomic code 0 is 64-bit compare-write untyped, reserved typed.
// R25: headerless pixel mask is all ones, ignored in 4x2.
// R26: reserved encodings modify nothing and return zeros.
`timescale 1ns/100ps
`default_nettype none
`include "surface_access_defines.vh"
module surface_access_unit (
    input wire i_clk,
    input wire i_reset,
    input wire i_req_valid,
    output wire o_req_ready,
    input wire [1:0] i_req_kind,
    input wire i_req_typed,
    input wire [13:0] i_req_desc,
    input wire i_req_has_header,
    input wire [15:0] i_req_pixel_mask,
    input wire [15:0] i_req_exec_mask,
    input wire [3:0] i_req_slot,
    input wire [2:0] i_surf_type,
    input wire i_surf_array,
    input wire [1:0] i_surf_format,
    input wire [`MEM_AW-1:0] i_surf_dwords,
    input wire [`MEM_AW-1:0] i_surf_pitch,
    input wire [`MEM_AW-1:0] i_surf_slice,
    input wire [31:0] i_addr_u,
    input wire [31:0] i_addr_v,
    input wire [31:0] i_addr_r,
    input wire [127:0] i_wdata,
    input wire [63:0] i_src0,
    input wire [63:0] i_src1,
    output reg o_rsp_valid,
    input wire i_rsp_ready,
    output reg [127:0] o_rsp_data,
    output reg [3:0] o_rsp_chan_en,
    output reg o_rsp_active,
    output reg [15:0] o_slot_mask,
    output reg o_bad_encoding
);
    reg [31:0] mem_r [0:`MEM_WORDS-1];
    wire [35:0] fifo_in;
    wire fifo_ready;
    wire fifo_valid;
    wire [35:0] fifo_out;
    reg [1:0] ch_r;
    reg [127:0] hold_data_r;
    reg [3:0] hold_en_r;
    reg hold_act_r;
    localparam ST_IDLE = 1'b0;
    localparam ST_OUT = 1'b1;
    reg st_r;

    // ------------------------------------------------------------
    // slot mask
    // ------------------------------------------------------------
    wire [1:0] mode = i_req_typed ? `SLOT_8 : i_req_desc[`DESC_MODE_HI:`DESC_MODE_LO]; // [R22]
    wire [15:0] pmask = i_req_has_header ? i_req_pixel_mask : 16'hffff; // [R25] [R17]
    wire grp_hi = i_req_typed & i_req_has_header & i_req_desc[`DESC_SLOT_GROUP_BIT]; // [R20]
    wire [7:0] pm8 = grp_hi ? pmask[15:8] : pmask[7:0]; // [R16]
    reg [15:0] slots;
    always @*
    begin
        case (mode)
            `SLOT_16: slots = i_req_exec_mask & pmask; // [R15]
            `SLOT_8: slots = {8'h00, i_req_exec_mask[7:0] & pm8}; // [R16]
            `SLOT_4X2: slots = {14'h0000, |i_req_exec_mask[7:4], |i_req_exec_mask[3:0]}; // [R18]
            default: slots = 16'h0000;
        endcase
    end
    wire active = slots[i_req_slot];

    // ------------------------------------------------------------
    // address
    // ------------------------------------------------------------
    wire [3:0] op = i_req_desc[11:8];
    wire is_atomic = (i_req_kind == `KIND_ATOMIC);
    wire bad = (mode == `SLOT_RSVD) || (i_req_kind == 2'h3)
        || (is_atomic && i_req_typed && op == `ATOMIC_COMPARE_WRITE_64)
        || (mode == `SLOT_4X2 && !is_atomic && !i_req_typed && i_req_kind != `KIND_READ); // [R26] [R24]
    // the 64-bit compare-write answers with red and green, other atomics with red only
    wire [3:0] chmask = is_atomic ? ((!i_req_typed && op == `ATOMIC_COMPARE_WRITE_64) ? 4'hc : 4'he)
        : i_req_desc[`DESC_CHMASK_HI:`DESC_CHMASK_LO]; // [R21] [R11] [R04]
    reg [31:0] base;
    always @*
    begin
        case (i_surf_type) // [R23]
            `SURF_BUF: base = i_req_typed ? i_addr_u : {2'b00, i_addr_u[31:2]}; // [R08]
            `SURF_STRBUF: base = i_addr_u * {24'h000000, i_surf_pitch} + {2'b00, i_addr_v[31:2]}; // [R09]
            `SURF_2D: base = i_addr_u + i_addr_v * {24'h000000, i_surf_pitch}
                + (i_surf_array ? i_addr_r * {24'h000000, i_surf_slice} : 32'h00000000);
            `SURF_3D: base = i_addr_u + i_addr_v * {24'h000000, i_surf_pitch} + i_addr_r * {24'h000000, i_surf_slice};
            default: base = i_surf_array ? i_addr_u + i_addr_v * {24'h000000, i_surf_pitch} : i_addr_u;
        endcase
    end
    wire wide = is_atomic && !i_req_typed && op == `ATOMIC_COMPARE_WRITE_64; // [R04]
    wire [2:0] span = i_req_typed ? 3'd1 : (wide ? 3'd2 : 3'd4);

    // ------------------------------------------------------------
    // per-channel bounds and data path
    // ------------------------------------------------------------
    wire [31:0] old0 = mem_r[base[`MEM_AW-1:0]];
    wire [31:0] old1 = mem_r[base[`MEM_AW-1:0] + 1'b1];
    wire inb0 = base < {24'h000000, i_surf_dwords};
    wire inb1 = (base + 32'h1) < {24'h000000, i_surf_dwords};
    wire [31:0] s0 = i_src0[31:0];
    reg [31:0] nv;
    always @*
    begin
        case (op) // [R02] [R06] [R07]
            `ATOMIC_AND: nv = old0 & s0;
            `ATOMIC_OR: nv = old0 | s0;
            `ATOMIC_XOR: nv = old0 ^ s0;
            `ATOMIC_MOVE: nv = s0;
            `ATOMIC_INCREMENT: nv = old0 + 32'h1;
            `ATOMIC_DECREMENT: nv = old0 - 32'h1;
            `ATOMIC_PRE_DECREMENT: nv = old0 - 32'h1;
            `ATOMIC_ADD: nv = old0 + s0;
            `ATOMIC_SUBTRACT: nv = old0 - s0;
            `ATOMIC_REVERSE_SUBTRACT: nv = s0 - old0;
            `ATOMIC_SIGNED_MAX: nv = ($signed(old0) > $signed(s0)) ? old0 : s0;
            `ATOMIC_SIGNED_MIN: nv = ($signed(old0) < $signed(s0)) ? old0 : s0;
            `ATOMIC_UNSIGNED_MAX: nv = (old0 > s0) ? old0 : s0;
            `ATOMIC_UNSIGNED_MIN: nv = (old0 < s0) ? old0 : s0;
            `ATOMIC_COMPARE_WRITE: nv = (s0 == old0) ? i_src1[31:0] : old0; // [R03]
            default: nv = old0;
        endcase
    end
    wire cmp64 = ({old1, old0} == i_src0); // [R04]

    // typed conversion: float formats take the dword as float32 bit pattern unchanged here,
    // integer formats store the u32/s32 value directly
    function [31:0] conv;
        input [1:0] fmt;
        input [31:0] d;
        begin
            case (fmt) // [R12]
                `FMT_UINT: conv = d;
                `FMT_SINT: conv = d;
                default: conv = d;
            endcase
        end
    endfunction

    // ------------------------------------------------------------
    // request execution: whole read-modify-write in one edge
    // ------------------------------------------------------------
    wire take = i_req_valid && st_r == ST_IDLE && !i_reset;
    reg [127:0] rd;
    // one loop index per process, so no variable has two drivers
    integer kr;
    integer kw;
    integer kp;
    always @*
    begin
        rd = 128'h0;
        for (kr = 0; kr < 4; kr = kr + 1)
        begin
            if (kr < span && ((base + kr) < {24'h000000, i_surf_dwords}))
                rd[kr*32 +: 32] = mem_r[base[`MEM_AW-1:0] + kr[`MEM_AW-1:0]]; // [R10] [R13] [R19]
        end
    end
    always @(posedge i_clk)
    begin
        if (take && active && !bad)
        begin
            if (is_atomic)
            begin
                if (wide)
                begin
                    if (cmp64 && inb0 && inb1) // [R01] [R19]
                    begin
                        mem_r[base[`MEM_AW-1:0]] <= i_src1[31:0];
                        mem_r[base[`MEM_AW-1:0] + 1'b1] <= i_src1[63:32];
                    end
                end
                else if (inb0) // [R01] [R11] [R19]
                    mem_r[base[`MEM_AW-1:0]] <= nv;
            end
            else if (i_req_kind == `KIND_WRITE)
            begin
                for (kw = 0; kw < 4; kw = kw + 1)
                begin
                    if (kw < span && !chmask[kw] && ((base + kw) < {24'h000000, i_surf_dwords})) // [R19] [R21]
                        mem_r[base[`MEM_AW-1:0] + kw[`MEM_AW-1:0]] <= i_req_typed ?
                            conv(i_surf_format, i_wdata[kw*32 +: 32]) : i_wdata[kw*32 +: 32]; // [R12] [R13]
                end
            end
        end
    end

    // ------------------------------------------------------------
    // response formation
    // ------------------------------------------------------------
    reg [127:0] rsp;
    always @*
    begin
        rsp = 128'h0;
        if (!bad && active)
        begin
            if (is_atomic)
            begin
                if (wide)
                    rsp[63:0] = {inb1 ? old1 : 32'h0, inb0 ? old0 : 32'h0}; // [R04]
                else if (inb0)
                    rsp[31:0] = (op == `ATOMIC_PRE_DECREMENT) ? nv : old0; // [R02]
            end
            else if (i_req_kind == `KIND_READ)
            begin
                for (kp = 0; kp < 4; kp = kp + 1)
                begin
                    if (!chmask[kp])
                        rsp[kp*32 +: 32] = rd[kp*32 +: 32]; // [R21]
                end
            end
        end
    end

    // response dwords stream through the fifo one channel at a time
    always @(posedge i_clk)
    begin
        if (i_reset)
        begin
            st_r <= ST_IDLE;
            ch_r <= 2'h0;
            hold_data_r <= 128'h0;
            hold_en_r <= 4'h0;
            hold_act_r <= 1'b0;
            o_slot_mask <= 16'h0000;
            o_bad_encoding <= 1'b0;
        end
        else
        begin
            case (st_r)
                ST_IDLE:
                begin
                    if (take)
                    begin
                        st_r <= ST_OUT;
                        ch_r <= 2'h0;
                        hold_data_r <= rsp;
                        hold_en_r <= bad ? 4'hf : ~chmask;
                        hold_act_r <= active & ~bad;
                        o_slot_mask <= slots;
                        o_bad_encoding <= bad;
                    end
                end
                ST_OUT:
                begin
                    if (fifo_ready)
                    begin
                        ch_r <= ch_r + 2'h1;
                        if (ch_r == 2'h3)
                            st_r <= ST_IDLE;
                    end
                end
                default: st_r <= ST_IDLE;
            endcase
        end
    end
    assign o_req_ready = (st_r == ST_IDLE);
    wire push = (st_r == ST_OUT) && hold_en_r[ch_r];
    // last marks the highest enabled channel, so the output stage knows the answer is whole
    wire last_ch = ((hold_en_r >> ch_r) == 4'h1);
    assign fifo_in = {hold_act_r, last_ch, ch_r, hold_data_r[ch_r*32 +: 32]};

    result_fifo #(.WIDTH(36), .DEPTH(`FIFO_DEPTH), .AW(2)) u_fifo (
        .i_clk(i_clk),
        .i_reset(i_reset),
        .i_valid(push),
        .o_ready(fifo_ready),
        .i_data(fifo_in),
        .o_valid(fifo_valid),
        .i_ready(!o_rsp_valid),
        .o_data(fifo_out)
    );

    // ------------------------------------------------------------
    // output register: accumulates channels of one response
    // ------------------------------------------------------------
    // each channel lands at its own index; valid rises with the last enabled channel
    always @(posedge i_clk)
    begin
        if (i_reset)
        begin
            o_rsp_valid <= 1'b0;
            o_rsp_data <= 128'h0;
            o_rsp_chan_en <= 4'h0;
            o_rsp_active <= 1'b0;
        end
        else
        begin
            if (o_rsp_valid && i_rsp_ready)
            begin
                o_rsp_valid <= 1'b0;
                o_rsp_data <= 128'h0;
                o_rsp_chan_en <= 4'h0;
            end
            if (fifo_valid && !o_rsp_valid)
            begin
                o_rsp_data[fifo_out[33:32]*32 +: 32] <= fifo_out[31:0]; // [R10]
                o_rsp_chan_en[fifo_out[33:32]] <= 1'b1; // [R21]
                o_rsp_active <= fifo_out[35];
                o_rsp_valid <= fifo_out[34];
            end
        end
    end
endmodule // surface_access_unit
`default_nettype wire
